/* File: cmm_exec.sv */
`timescale 1ns/1ps
module cmm_exec #(
   parameter logic [11:0] ACC_ADDR = cmm_pkg::ACC_ADDR_DFLT
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // instruction stream, taken in the first phase
   input wire logic [15:0] instr_i,
   input wire logic instr_valid_i,
   // data memory
   output cmm_pkg::cmm_mem_req_s mem_o,
   input wire logic [7:0] mem_rdata_i,
   // core registers
   output logic [7:0] acc_o,
   output logic [7:0] bank_o,
   output cmm_pkg::cmm_ptr_t ptr_o,
   output logic [15:0] prod_o,
   output cmm_pkg::cmm_flags_s flags_o,
   // status
   output logic [3:0] phase_o,
   output logic unsupported_o
);

   logic [3:0] q;
   logic live, src_is_acc, lit_op;
   logic [15:0] ir;
   cmm_pkg::cmm_op_e op;
   cmm_pkg::cmm_st_e st;
   logic [1:0] ptr_sel;
   logic [7:0] opnd, res, hold, data_in, next_res;

   cmm_phase_gen #(.N(cmm_pkg::PHASES)) u_phase (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .phase_o(q)
   );
   assign phase_o = q;
   function automatic cmm_pkg::cmm_op_e decode(input logic [15:0] w);
      cmm_pkg::cmm_op_e d;
      d = cmm_pkg::OP_NONE;
      if (w[15:8] == cmm_pkg::OPC_OR_LIT) d = cmm_pkg::OP_OR_LIT;
      else if (w[15:8] == cmm_pkg::OPC_BANK_LIT) d = cmm_pkg::OP_BANK;
      else if (w[15:8] == cmm_pkg::OPC_ACC_LIT) d = cmm_pkg::OP_ACC_LIT;
      else if (w[15:8] == cmm_pkg::OPC_MUL_LIT) d = cmm_pkg::OP_MUL_LIT;
      else if (w[15:9] == cmm_pkg::OPC_MUL_REG) d = cmm_pkg::OP_MUL_REG;
      else if (w[15:9] == cmm_pkg::OPC_STORE) d = cmm_pkg::OP_STORE;
      else if (w[15:10] == cmm_pkg::OPC_OR_FILE) d = cmm_pkg::OP_OR_FILE;
      else if (w[15:10] == cmm_pkg::OPC_FMOVE) d = cmm_pkg::OP_FMOVE;
      else if (w[15:6] == cmm_pkg::OPC_PTR) d = cmm_pkg::OP_PTR;
      else if (w[15:12] == cmm_pkg::OPC_FULL) d = cmm_pkg::OP_FULL;
      return d;
   endfunction

   // 8-bit offset inside a bank; access bank splits low memory and high registers
   function automatic logic [11:0] banked(input logic [7:0] f, input logic a, input logic [7:0] b);
      logic [3:0] hi;
      hi = (f >= cmm_pkg::ACCESS_SPLIT) ? cmm_pkg::ACCESS_HI_BANK : cmm_pkg::ACCESS_LO_BANK;
      return a ? {b[3:0], f} : {hi, f}; // RQ4 RQ5
   endfunction

   // take a word in the first phase; second words keep the decoded operation
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         live <= 1'b0;
         ir <= 16'h0000;
         op <= cmm_pkg::OP_NONE;
         ptr_sel <= 2'h0;
         src_is_acc <= 1'b0;
         unsupported_o <= 1'b0;
      end else if (q[0]) begin
         live <= instr_valid_i;
         unsupported_o <= 1'b0;
         if (instr_valid_i) begin
            ir <= instr_i;
            if (st == cmm_pkg::ST_FIRST) begin
               op <= decode(instr_i);
               ptr_sel <= instr_i[5:4];
               src_is_acc <= (instr_i[11:0] == ACC_ADDR); // RQ7
               unsupported_o <= (decode(instr_i) == cmm_pkg::OP_NONE);
            end
         end
      end
   end

   // sequencing of the two-word forms, advanced at the end of the last phase
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         st <= cmm_pkg::ST_FIRST;
      end else if (q[3] && live) begin
         case (st)
            cmm_pkg::ST_FIRST: begin
               if (op == cmm_pkg::OP_PTR) st <= cmm_pkg::ST_PTR2; // RQ2
               else if (op == cmm_pkg::OP_FULL) st <= cmm_pkg::ST_MOV2; // RQ9
               else st <= cmm_pkg::ST_FIRST;
            end
            cmm_pkg::ST_PTR2: st <= cmm_pkg::ST_FIRST;
            cmm_pkg::ST_MOV2: st <= cmm_pkg::ST_FIRST;
            default: st <= cmm_pkg::ST_FIRST;
         endcase
      end
   end

   // memory port: read in the second phase, write in the last phase
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         mem_o <= '0;
      end else if (q[0]) begin
         mem_o.wr <= 1'b0;
         mem_o.rd <= 1'b0;
         if (instr_valid_i && st == cmm_pkg::ST_FIRST) begin
            case (decode(instr_i))
               cmm_pkg::OP_OR_FILE, cmm_pkg::OP_FMOVE, cmm_pkg::OP_MUL_REG: begin
                  mem_o.rd <= 1'b1;
                  mem_o.addr <= banked(instr_i[7:0], instr_i[cmm_pkg::BANKED_BIT], bank_o); // RQ4 RQ5
               end
               cmm_pkg::OP_FULL: begin
                  // the accumulator is internal, so reading it costs no memory access
                  mem_o.rd <= (instr_i[11:0] != ACC_ADDR); // RQ6 RQ7
                  mem_o.addr <= instr_i[11:0]; // RQ6
               end
               default: mem_o.rd <= 1'b0;
            endcase
         end
      end else if (q[1]) begin
         mem_o.rd <= 1'b0;
      end else if (q[2] && live) begin
         mem_o.wdata <= next_res;
         case (op)
            cmm_pkg::OP_OR_FILE, cmm_pkg::OP_FMOVE: begin
               mem_o.wr <= ir[cmm_pkg::DEST_BIT]; // RQ3
               mem_o.addr <= banked(ir[7:0], ir[cmm_pkg::BANKED_BIT], bank_o);
            end
            cmm_pkg::OP_STORE: begin
               mem_o.wr <= 1'b1;
               mem_o.addr <= banked(ir[7:0], ir[cmm_pkg::BANKED_BIT], bank_o);
            end
            cmm_pkg::OP_FULL: begin
               mem_o.wr <= (st == cmm_pkg::ST_MOV2) && (ir[11:0] != ACC_ADDR); // RQ9 RQ7
               mem_o.addr <= ir[11:0]; // RQ6
               mem_o.wdata <= hold;
            end
            default: mem_o.wr <= 1'b0;
         endcase
      end else if (q[3]) begin
         mem_o.wr <= 1'b0;
      end
   end

   // operand source and result of the data phase
   always_comb begin
      lit_op = (op == cmm_pkg::OP_OR_LIT) || (op == cmm_pkg::OP_MUL_LIT);
      data_in = lit_op ? ir[7:0] : mem_rdata_i;
      case (op)
         cmm_pkg::OP_OR_LIT, cmm_pkg::OP_OR_FILE: next_res = acc_o | data_in; // RQ14
         cmm_pkg::OP_STORE: next_res = acc_o;
         default: next_res = data_in;
      endcase
   end

   // capture the data phase; the full move keeps its source across the second word
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         opnd <= 8'h00;
         res <= 8'h00;
         hold <= 8'h00;
      end else if (q[2] && live) begin
         opnd <= data_in;
         res <= next_res;
         if (op == cmm_pkg::OP_FULL && st == cmm_pkg::ST_FIRST) begin
            hold <= src_is_acc ? acc_o : mem_rdata_i; // RQ7
         end
      end
   end

   // accumulator and flags, written at the end of the last phase
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         acc_o <= cmm_pkg::ACC_RST;
         flags_o <= '0;
      end else if (q[3] && live) begin
         case (op)
            cmm_pkg::OP_OR_LIT: begin
               acc_o <= res; // RQ14
               flags_o <= '{neg: res[7], zero: (res == 8'h00)};
            end
            cmm_pkg::OP_OR_FILE, cmm_pkg::OP_FMOVE: begin
               if (!ir[cmm_pkg::DEST_BIT]) acc_o <= res; // RQ3
               flags_o <= '{neg: res[7], zero: (res == 8'h00)}; // RQ14 RQ15
            end
            cmm_pkg::OP_ACC_LIT: acc_o <= ir[7:0]; // RQ15
            cmm_pkg::OP_FULL: begin
               if (st == cmm_pkg::ST_MOV2 && ir[11:0] == ACC_ADDR) acc_o <= hold; // RQ7
            end
            default: acc_o <= acc_o; // multiplies leave flags alone RQ13
         endcase
      end
   end

   // bank select register
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         bank_o <= cmm_pkg::BANK_RST;
      end else if (q[3] && live && op == cmm_pkg::OP_BANK) begin
         bank_o <= ir[7:0]; // RQ10
      end
   end

   // indirect pointers; selector value 3 names no pointer and writes nothing
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ptr_o <= {cmm_pkg::NUM_PTR{cmm_pkg::PTR_RST}};
      end else if (q[3] && live && op == cmm_pkg::OP_PTR && ptr_sel < 2'(cmm_pkg::NUM_PTR)) begin
         if (st == cmm_pkg::ST_FIRST) begin
            ptr_o[ptr_sel] <= {ir[3:0], 8'h00}; // RQ1 RQ2
         end else if (st == cmm_pkg::ST_PTR2) begin
            ptr_o[ptr_sel][7:0] <= ir[7:0]; // RQ1 RQ2
         end
      end
   end

   // product pair: zero-extend so the full 16-bit unsigned product is kept
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         prod_o <= cmm_pkg::PROD_RST;
      end else if (q[3] && live && (op == cmm_pkg::OP_MUL_LIT || op == cmm_pkg::OP_MUL_REG)) begin
         prod_o <= {8'h00, acc_o} * {8'h00, opnd}; // RQ11 RQ12
      end
   end

   property p_prod;
      @(posedge clk_i) disable iff (!reset_n_i)
      (q[3] && live && (op == cmm_pkg::OP_MUL_LIT || op == cmm_pkg::OP_MUL_REG))
      |=> (prod_o == ({8'h00, $past(acc_o)} * {8'h00, $past(opnd)}));
   endproperty
   a_prod: assert property (p_prod) else $error("product pair wrong"); // RQ11
   property p_mul_quiet;
      @(posedge clk_i) disable iff (!reset_n_i)
      (q[3] && live && (op == cmm_pkg::OP_MUL_LIT || op == cmm_pkg::OP_MUL_REG))
      |=> ($stable(flags_o) && $stable(acc_o));
   endproperty
   a_mul_quiet: assert property (p_mul_quiet) else $error("multiply changed flags or acc"); // RQ13
   property p_banked;
      @(posedge clk_i) disable iff (!reset_n_i)
      (q[0] && st == cmm_pkg::ST_FIRST && instr_valid_i &&
       instr_i[15:10] == cmm_pkg::OPC_OR_FILE && instr_i[cmm_pkg::BANKED_BIT])
      |=> (mem_o.rd && mem_o.addr == {$past(bank_o[3:0]), $past(instr_i[7:0])});
   endproperty
   a_banked: assert property (p_banked) else $error("banked address wrong"); // RQ4
   property p_access;
      @(posedge clk_i) disable iff (!reset_n_i)
      (q[0] && st == cmm_pkg::ST_FIRST && instr_valid_i &&
       instr_i[15:10] == cmm_pkg::OPC_FMOVE && !instr_i[cmm_pkg::BANKED_BIT])
      |=> (mem_o.rd && mem_o.addr[11:8] == (($past(instr_i[7:0]) >= cmm_pkg::ACCESS_SPLIT) ?
           cmm_pkg::ACCESS_HI_BANK : cmm_pkg::ACCESS_LO_BANK));
   endproperty
   a_access: assert property (p_access) else $error("access bank address wrong"); // RQ4
   property p_dest_acc;
      @(posedge clk_i) disable iff (!reset_n_i)
      (q[2] && live && op == cmm_pkg::OP_OR_FILE && !ir[cmm_pkg::DEST_BIT])
      |=> !mem_o.wr ##1 (acc_o == $past(res));
   endproperty
   a_dest_acc: assert property (p_dest_acc) else $error("destination bit not honoured"); // RQ3
   property p_full_no_read;
      @(posedge clk_i) disable iff (!reset_n_i)
      (q[1] && st == cmm_pkg::ST_MOV2) |-> !mem_o.rd;
   endproperty
   a_full_no_read: assert property (p_full_no_read) else $error("read in second move cycle"); // RQ9
   property p_full_write;
      @(posedge clk_i) disable iff (!reset_n_i)
      (q[2] && live && st == cmm_pkg::ST_MOV2 && ir[11:0] != ACC_ADDR)
      |=> (mem_o.wr && mem_o.addr == $past(ir[11:0]) && mem_o.wdata == $past(hold));
   endproperty
   a_full_write: assert property (p_full_write) else $error("full move write wrong"); // RQ6
   property p_ptr_high;
      @(posedge clk_i) disable iff (!reset_n_i)
      (q[3] && live && st == cmm_pkg::ST_FIRST && op == cmm_pkg::OP_PTR && ptr_sel != 2'h3)
      |=> (ptr_o[$past(ptr_sel)][11:8] == $past(ir[3:0])) && (st == cmm_pkg::ST_PTR2);
   endproperty
   a_ptr_high: assert property (p_ptr_high) else $error("pointer high part wrong"); // RQ2
   property p_bank;
      @(posedge clk_i) disable iff (!reset_n_i)
      (q[3] && live && op == cmm_pkg::OP_BANK) |=> (bank_o == $past(ir[7:0]));
   endproperty
   a_bank: assert property (p_bank) else $error("bank select not loaded"); // RQ10
   property p_or_flags;
      @(posedge clk_i) disable iff (!reset_n_i)
      (q[3] && live && op == cmm_pkg::OP_OR_LIT)
      |=> (acc_o == $past(res)) && (flags_o.zero == ($past(res) == 8'h00)) && (flags_o.neg == $past(res[7]));
   endproperty
   a_or_flags: assert property (p_or_flags) else $error("or result or flags wrong"); // RQ14
   property p_lit_quiet;
      @(posedge clk_i) disable iff (!reset_n_i)
      (q[3] && live && (op == cmm_pkg::OP_ACC_LIT || op == cmm_pkg::OP_STORE)) |=> $stable(flags_o);
   endproperty
   a_lit_quiet: assert property (p_lit_quiet) else $error("literal load changed flags"); // RQ15

endmodule

/* File: cmm_pkg.sv */
// How it works
// (RQ1) pointer load puts a 12-bit literal into the pointer chosen by a 2-bit selector
// (RQ2) pointer load spans two words: high part in cycle one, low byte in cycle two
// (RQ3) destination bit 0 sends the result to the accumulator, 1 back to the register
// (RQ4) access bit 0 uses the access bank, 1 uses the bank select register
// (RQ5) single-word register forms carry an 8-bit offset within the selected bank
// (RQ6) full-address move carries 12-bit source and destination anywhere in data space
// (RQ7) full-address move may use the accumulator as source or destination
// (RQ8) software never targets program counter low or stack top bytes with full moves
// (RQ9) full move: two cycles, source read first, no read second, write in last phase
// (RQ10) bank literal load writes its 8-bit literal into the bank select register
// (RQ11) literal multiply puts unsigned accumulator times literal into product pair
// (RQ12) register multiply puts unsigned accumulator times register into product pair
// (RQ13) multiplies touch no status flag, no zero, carry or overflow indication
// (RQ14) or forms combine accumulator with literal or register, update negative and zero
// (RQ15) literal loads and stores leave flags alone; plain move updates negative and zero
package cmm_pkg;

   // timing: one instruction cycle is split into phases of the core clock
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned TCY_NS = 100;
   localparam int unsigned PHASES = TCY_NS * CLK_MHZ / 1000;

   // data space layout
   localparam logic [11:0] ACC_ADDR_DFLT = 12'hFE8;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   localparam int unsigned NUM_PTR = 3;

   // instruction fields
   localparam int unsigned DEST_BIT = 9;
   localparam int unsigned BANKED_BIT = 8;
   localparam logic [7:0] OPC_OR_LIT = 8'h09;
   localparam logic [7:0] OPC_BANK_LIT = 8'h01;
   localparam logic [7:0] OPC_ACC_LIT = 8'h0E;
   localparam logic [7:0] OPC_MUL_LIT = 8'h0D;
   localparam logic [6:0] OPC_MUL_REG = 7'h01;
   localparam logic [6:0] OPC_STORE = 7'h37;
   localparam logic [5:0] OPC_OR_FILE = 6'h04;
   localparam logic [5:0] OPC_FMOVE = 6'h14;
   localparam logic [9:0] OPC_PTR = 10'h3B8;
   localparam logic [3:0] OPC_FULL = 4'hC;

   // reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] BANK_RST = 8'h00;
   localparam logic [15:0] PROD_RST = 16'h0000;
   localparam logic [11:0] PTR_RST = 12'h000;
   localparam logic [3:0] PHASE_RST = 4'h1;

   typedef enum logic [10:0] {
      OP_NONE = 11'h001,
      OP_OR_LIT = 11'h002,
      OP_OR_FILE = 11'h004,
      OP_PTR = 11'h008,
      OP_FMOVE = 11'h010,
      OP_FULL = 11'h020,
      OP_BANK = 11'h040,
      OP_ACC_LIT = 11'h080,
      OP_STORE = 11'h100,
      OP_MUL_LIT = 11'h200,
      OP_MUL_REG = 11'h400
   } cmm_op_e;

   typedef enum logic [2:0] {
      ST_FIRST = 3'h1,
      ST_PTR2 = 3'h2,
      ST_MOV2 = 3'h4
   } cmm_st_e;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } cmm_mem_req_s;

   typedef struct packed {
      logic neg;
      logic zero;
   } cmm_flags_s;

   typedef logic [NUM_PTR-1:0][11:0] cmm_ptr_t;

endpackage

/* File: cmm_phase_gen.sv */
`timescale 1ns/1ps
// splits the instruction cycle into one-hot phases, bit 0 is the first phase
module cmm_phase_gen #(
   parameter int unsigned N = cmm_pkg::PHASES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // phase strobes
   output logic [N-1:0] phase_o
);

   // free-running ring; it never stalls, a missing word just idles a whole cycle
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         phase_o <= N'(cmm_pkg::PHASE_RST);
      end else begin
         phase_o <= {phase_o[N-2:0], phase_o[N-1]};
      end
   end

endmodule

/* File: cmm_mem_model.sv */
`timescale 1ns/1ps
// data memory behind the block: a read answers in Q3, a write lands at the Q4 edge
module cmm_mem_model (
   // clock
   input wire logic clk_i,
   // requests from the block
   input wire cmm_pkg::cmm_mem_req_s req_i,
   // read data
   output logic [7:0] rdata_o
);
   logic [7:0] mem [4096];
   logic [7:0] rd_q = 8'hA5;

   // data holds only for the Q3 cycle, then toggles so a late sample never matches by luck
   always @(posedge clk_i) begin
      if (req_i.rd) begin
         rd_q <= mem[req_i.addr];
      end else begin
         rd_q <= ~rd_q;
      end
   end

   // plain always: the bench preloads cells by hierarchy as well
   always @(posedge clk_i) begin
      if (req_i.wr) begin
         mem[req_i.addr] <= req_i.wdata;
      end
   end

   assign rdata_o = rd_q;
endmodule

/* File: tb_cpu_move_or_multiply_ops.sv */
`timescale 1ns/1ps
module tb_cpu_move_or_multiply_ops;
   // stimulus and observed ports
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [15:0] instr_i = 16'h0000;
   logic instr_valid_i = 1'b0;
   cmm_pkg::cmm_mem_req_s mem_o;
   logic [7:0] mem_rdata_i;
   logic [7:0] acc_o;
   logic [7:0] bank_o;
   cmm_pkg::cmm_ptr_t ptr_o;
   logic [15:0] prod_o;
   cmm_pkg::cmm_flags_s flags_o;
   logic [3:0] phase_o;
   logic unsupported_o;
   logic unsup_seen;
   int fails = 0;
   int n_checks = 0;
   localparam logic [11:0] ACC = cmm_pkg::ACC_ADDR_DFLT;

   cmm_exec i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
      .mem_o(mem_o), .mem_rdata_i(mem_rdata_i), .acc_o(acc_o), .bank_o(bank_o), .ptr_o(ptr_o),
      .prod_o(prod_o), .flags_o(flags_o), .phase_o(phase_o), .unsupported_o(unsupported_o));
   cmm_mem_model i_mem (.clk_i(clk_i), .req_i(mem_o), .rdata_o(mem_rdata_i));

   // 40 MHz core clock
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one instruction cycle; the word is taken at the edge ending Q1, results settle after the Q4 edge
   task automatic exec(input logic [15:0] w, input logic v = 1'b1);
      int n;
      n = 0;
      while (phase_o !== 4'b0001) begin
         @(posedge clk_i);
         #2;
         n++;
         if (n > 8) begin
            fails++;
            $display("mismatch phase expected 1 seen %h", phase_o);
            test_done();
         end
      end
      instr_i = w;
      instr_valid_i = v;
      @(posedge clk_i);
      #2;
      unsup_seen = unsupported_o;
      instr_valid_i = 1'b0;
      repeat (3) @(posedge clk_i);
      #2;
   endtask

   task automatic lw(input logic [7:0] k);
      exec({8'h0E, k});
   endtask

   task automatic t_or_lit();
      lw(8'h9A);
      exec({8'h09, 8'h35});
      chk("acc", 16'h00BF, 16'(acc_o));
      chk("flags", 16'h0002, 16'(flags_o));
      lw(8'h00);
      chk("flags", 16'h0002, 16'(flags_o));
      exec({8'h09, 8'h00});
      chk("flags", 16'h0001, 16'(flags_o));
   endtask

   task automatic t_banked();
      exec({8'h01, 8'h05});
      chk("bank", 16'h0005, 16'(bank_o));
      i_mem.mem[12'h513] = 8'h13;
      i_mem.mem[12'h020] = 8'h40;
      i_mem.mem[12'hF85] = 8'h00;
      lw(8'h91);
      exec({6'h04, 1'b0, 1'b1, 8'h13});
      chk("acc", 16'h0093, 16'(acc_o));
      chk("mem513", 16'h0013, 16'(i_mem.mem[12'h513]));
      exec({6'h04, 1'b1, 1'b0, 8'h20});
      chk("mem020", 16'h00D3, 16'(i_mem.mem[12'h020]));
      chk("acc", 16'h0093, 16'(acc_o));
      exec({6'h14, 1'b0, 1'b0, 8'h85});
      chk("acc", 16'h0000, 16'(acc_o));
      chk("flags", 16'h0001, 16'(flags_o));
      lw(8'h4F);
      exec({7'h37, 1'b1, 8'hFF});
      chk("mem5ff", 16'h004F, 16'(i_mem.mem[12'h5FF]));
      chk("flags", 16'h0001, 16'(flags_o));
   endtask

   task automatic t_ptr();
      logic [11:0] ks [3];
      ks = '{12'hFFF, 12'h3AB, 12'h801};
      for (int s = 0; s < 3; s++) begin
         exec({10'h3B8, 2'(s), ks[s][11:8]});
         chk("ptr_hi", 16'(ks[s][11:8]), 16'(ptr_o[s][11:8]));
         exec(16'h0000, 1'b0);
         exec({8'hF0, ks[s][7:0]});
         chk("ptr", 16'(ks[s]), 16'(ptr_o[s]));
      end
   endtask

   task automatic t_full();
      i_mem.mem[12'h123] = 8'h33;
      i_mem.mem[12'hABC] = 8'h11;
      i_mem.mem[12'hFFF] = 8'h5A;
      // destinations stay clear of program counter and stack top bytes
      exec({4'hC, 12'h123});
      chk("memabc", 16'h0011, 16'(i_mem.mem[12'hABC]));
      exec({4'hF, 12'hABC});
      chk("memabc", 16'h0033, 16'(i_mem.mem[12'hABC]));
      lw(8'h6C);
      exec({4'hC, ACC});
      exec({4'hF, 12'h000});
      chk("mem000", 16'h006C, 16'(i_mem.mem[12'h000]));
      exec({4'hC, 12'hFFF});
      exec({4'hF, ACC});
      chk("acc", 16'h005A, 16'(acc_o));
   endtask

   task automatic t_mul();
      lw(8'hE2);
      exec({8'h09, 8'h00});
      exec({8'h0D, 8'hC4});
      chk("prod", 16'hAD08, prod_o);
      chk("acc", 16'h00E2, 16'(acc_o));
      chk("flags", 16'h0002, 16'(flags_o));
      i_mem.mem[12'h510] = 8'hB5;
      lw(8'hC4);
      exec({7'h01, 1'b1, 8'h10});
      chk("prod", 16'h8A94, prod_o);
      chk("acc", 16'h00C4, 16'(acc_o));
      chk("mem510", 16'h00B5, 16'(i_mem.mem[12'h510]));
      exec({8'h0D, 8'h00});
      chk("prod", 16'h0000, prod_o);
      chk("flags", 16'h0002, 16'(flags_o));
   endtask

   task automatic t_unsup();
      lw(8'h77);
      chk("unsup", 16'h0000, 16'(unsup_seen));
      exec(16'h0006);
      chk("unsup", 16'h0001, 16'(unsup_seen));
      chk("acc", 16'h0077, 16'(acc_o));
   endtask

   // main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      #2;
      reset_n_i = 1'b1;
      t_or_lit();
      t_banked();
      t_ptr();
      t_full();
      t_mul();
      t_unsup();
      test_done();
   end
endmodule
